// ===== rtl/bar_pkg.sv
// Shared constants, types and helper functions of the barometer register bank
package bar_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam int PRESS_W = 24;
  localparam int TEMP_W = 16;
  localparam int THS_W = 16;
  localparam int PAVG_W = 10;
  localparam int TAVG_W = 7;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_REF_LOW = 7'h08;
  localparam logic [ADDR_W-1:0] OFF_REF_MID = 7'h09;
  localparam logic [ADDR_W-1:0] OFF_REF_HIGH = 7'h0A;
  localparam logic [ADDR_W-1:0] OFF_IDENT = 7'h0F;
  localparam logic [ADDR_W-1:0] OFF_AVG_CFG = 7'h10;
  localparam logic [ADDR_W-1:0] OFF_CTRL_ONE = 7'h20;
  localparam logic [ADDR_W-1:0] OFF_CTRL_TWO = 7'h21;
  localparam logic [ADDR_W-1:0] OFF_CTRL_THREE = 7'h22;
  localparam logic [ADDR_W-1:0] OFF_CTRL_FOUR = 7'h23;
  localparam logic [ADDR_W-1:0] OFF_INT_CFG = 7'h24;
  localparam logic [ADDR_W-1:0] OFF_INT_CAUSE = 7'h25;
  localparam logic [ADDR_W-1:0] OFF_SAMPLE_STATE = 7'h27;
  localparam logic [ADDR_W-1:0] OFF_PRESS_LOW = 7'h28;
  localparam logic [ADDR_W-1:0] OFF_PRESS_MID = 7'h29;
  localparam logic [ADDR_W-1:0] OFF_PRESS_HIGH = 7'h2A;
  localparam logic [ADDR_W-1:0] OFF_TEMP_LOW = 7'h2B;
  localparam logic [ADDR_W-1:0] OFF_TEMP_HIGH = 7'h2C;
  localparam logic [ADDR_W-1:0] OFF_QUEUE_CTRL = 7'h2E;
  localparam logic [ADDR_W-1:0] OFF_QUEUE_STATE = 7'h2F;
  localparam logic [ADDR_W-1:0] OFF_THS_LOW = 7'h30;
  localparam logic [ADDR_W-1:0] OFF_THS_HIGH = 7'h31;
  localparam logic [ADDR_W-1:0] OFF_DEF_P_LOW = 7'h39;
  localparam logic [ADDR_W-1:0] OFF_DEF_P_HIGH = 7'h3A;

  // Reset values
  localparam logic [DATA_W-1:0] RST_ZERO = 8'h00;
  localparam logic [DATA_W-1:0] RST_AVG_CFG = 8'h05;
  localparam logic [DATA_W-1:0] RST_DEF_P_LOW = 8'h38;
  localparam logic [DATA_W-1:0] RST_DEF_P_HIGH = 8'h00;

  // Identification code: arbitrary neutral value
  localparam logic [DATA_W-1:0] IDENT_CODE = 8'h5A;

  // Field positions and masks
  localparam int CTRL1_DIFF_EN_BIT = 3;
  localparam int CTRL1_AZ_CLEAR_BIT = 1;
  localparam int CTRL2_BOOT_BIT = 7;
  localparam int CTRL2_AUTOZERO_BIT = 1;
  localparam int AVG_P_LSB = 2;
  localparam int AVG_T_LSB = 0;
  localparam logic [DATA_W-1:0] AVG_CFG_MASK = 8'h0F;

  // Averaging counts
  localparam logic [PAVG_W-1:0] PAVG_8 = 10'h008;
  localparam logic [PAVG_W-1:0] PAVG_32 = 10'h020;
  localparam logic [PAVG_W-1:0] PAVG_128 = 10'h080;
  localparam logic [PAVG_W-1:0] PAVG_512 = 10'h200;
  localparam logic [TAVG_W-1:0] TAVG_8 = 7'h08;
  localparam logic [TAVG_W-1:0] TAVG_16 = 7'h10;
  localparam logic [TAVG_W-1:0] TAVG_32 = 7'h20;
  localparam logic [TAVG_W-1:0] TAVG_64 = 7'h40;

  // Host register request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } bar_req_t;

  // Raw sample from the measurement chain
  typedef struct packed {
    logic valid;
    logic [PRESS_W-1:0] pressure;
    logic [TEMP_W-1:0] temperature;
  } bar_sample_t;

  // Control bytes handed to the rest of the sensor
  typedef struct packed {
    logic [DATA_W-1:0] ctrl_one;
    logic [DATA_W-1:0] ctrl_two;
    logic [DATA_W-1:0] ctrl_three;
    logic [DATA_W-1:0] ctrl_four;
    logic [DATA_W-1:0] int_cfg;
    logic [DATA_W-1:0] queue_ctrl;
    logic [THS_W-1:0] threshold;
    logic [THS_W-1:0] default_pressure;
  } bar_ctrl_t;

  // Autozero sequencer states
  typedef enum logic [2:0] {
    AZ_IDLE = 3'b001,
    AZ_WAIT = 3'b010,
    AZ_LOAD = 3'b100
  } bar_az_state_t;

  // Address compare used across the decode
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] off);
    return addr == off;
  endfunction : addr_hit

  // Pressure averaging count from its 2-bit code
  function automatic logic [PAVG_W-1:0] pressure_avg_count(input logic [1:0] code);
    unique case (code)
      2'h0: return PAVG_8;
      2'h1: return PAVG_32;
      2'h2: return PAVG_128;
      2'h3: return PAVG_512;
    endcase
  endfunction : pressure_avg_count

  // Temperature averaging count from its 2-bit code
  function automatic logic [TAVG_W-1:0] temperature_avg_count(input logic [1:0] code);
    unique case (code)
      2'h0: return TAVG_8;
      2'h1: return TAVG_16;
      2'h2: return TAVG_32;
      2'h3: return TAVG_64;
    endcase
  endfunction : temperature_avg_count

endpackage : bar_pkg

// ===== rtl/bar_avg_decode.sv
// Averaging count decode of the averaging configuration byte
`timescale 1ns/1ps
module bar_avg_decode
(
  input wire logic [bar_pkg::DATA_W-1:0] avg_cfg_i,
  output logic [bar_pkg::PAVG_W-1:0] pressure_avg_count_o,
  output logic [bar_pkg::TAVG_W-1:0] temp_avg_count_o
);
  import bar_pkg::*;

  wire [1:0] pressure_average_select = avg_cfg_i[AVG_P_LSB +: 2];
  wire [1:0] temperature_average_select = avg_cfg_i[AVG_T_LSB +: 2];

  // Map the two codes onto internal average counts
  assign pressure_avg_count_o = pressure_avg_count(pressure_average_select);
  assign temp_avg_count_o = temperature_avg_count(temperature_average_select);

endmodule : bar_avg_decode

// ===== rtl/bar_ref_calc.sv
// Reference pressure arithmetic: reported sum and threshold compare
`timescale 1ns/1ps
module bar_ref_calc
(
  input wire logic [bar_pkg::PRESS_W-1:0] sensor_i,
  input wire logic [bar_pkg::PRESS_W-1:0] reference_i,
  input wire logic [bar_pkg::THS_W-1:0] threshold_i,
  input wire logic enable_i,
  output logic [bar_pkg::PRESS_W-1:0] sum_o,
  output logic high_o,
  output logic low_o
);
  import bar_pkg::*;

  wire signed [PRESS_W-1:0] diff = signed'(sensor_i - reference_i);
  wire signed [PRESS_W-1:0] ths_pos = signed'({{(PRESS_W-THS_W){1'b0}}, threshold_i});
  wire signed [PRESS_W-1:0] ths_neg = signed'(PRESS_W'(0) - ths_pos);

  // Reported pressure is the sensor value plus the two's-complement reference
  assign sum_o = sensor_i + reference_i;

  // Threshold detection against the reference, gated by the enable bit
  assign high_o = enable_i & (diff > ths_pos);
  assign low_o = enable_i & (diff < ths_neg);

endmodule : bar_ref_calc

// ===== rtl/bar_register_map.sv
// Register bank of the barometer: storage, decode, autozero and results
//
// Overview of operation
// - Every register is one byte wide and is picked by a 7-bit address.
// - Three read/write bytes at 08h, 09h and 0Ah form a 24-bit signed reference, reset to 0.
// - The reference is added to the sensor pressure to give the reported pressure.
// - The reference feeds threshold detection and autozero, which control one at 20h clears.
// - Address 0Fh reads a fixed identification code and ignores writes.
// - Bits 3:2 at 10h select 8, 32, 128 or 512 pressure averages.
// - Bits 1:0 at 10h select 8, 16, 32 or 64 temperature averages.
// - The averaging register resets to 05h with its upper four bits at zero.
// - Calibration registers are restored at power-up and on a reboot request.
`timescale 1ns/1ps
module bar_register_map
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  input wire bar_pkg::bar_req_t req_i,
  output logic [bar_pkg::DATA_W-1:0] rdata_o,
  output logic rvalid_o,
  input wire bar_pkg::bar_sample_t sample_i,
  input wire logic [bar_pkg::DATA_W-1:0] int_cause_i,
  input wire logic [bar_pkg::DATA_W-1:0] sample_state_i,
  input wire logic [bar_pkg::DATA_W-1:0] queue_state_i,
  output bar_pkg::bar_ctrl_t ctrl_o,
  output logic [bar_pkg::PRESS_W-1:0] reference_o,
  output logic pressure_high_o,
  output logic pressure_low_o,
  output logic [bar_pkg::PAVG_W-1:0] pressure_avg_count_o,
  output logic [bar_pkg::TAVG_W-1:0] temp_avg_count_o
);
  import bar_pkg::*;

  logic [DATA_W-1:0] ref_low_reg, ref_mid_reg, ref_high_reg;
  logic [DATA_W-1:0] avg_cfg_reg;
  logic [DATA_W-1:0] ctrl_one_reg, ctrl_two_reg, ctrl_three_reg, ctrl_four_reg;
  logic [DATA_W-1:0] int_cfg_reg, queue_ctrl_reg;
  logic [DATA_W-1:0] ths_low_reg, ths_high_reg;
  logic [DATA_W-1:0] def_low_reg, def_high_reg;
  logic [PRESS_W-1:0] press_reg;
  logic [TEMP_W-1:0] temp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic rvalid_reg;
  bar_az_state_t az_reg, az_next;
  logic [PRESS_W-1:0] sum_w;

  // Write strobes, one per writable register
  wire wr_go = ce_i & req_i.wr;
  wire [ADDR_W-1:0] wa = req_i.addr;
  wire wr_ref_low = wr_go & addr_hit(wa, OFF_REF_LOW);
  wire wr_ref_mid = wr_go & addr_hit(wa, OFF_REF_MID);
  wire wr_ref_high = wr_go & addr_hit(wa, OFF_REF_HIGH);
  wire wr_avg_cfg = wr_go & addr_hit(wa, OFF_AVG_CFG);
  wire wr_ctrl_one = wr_go & addr_hit(wa, OFF_CTRL_ONE);
  wire wr_ctrl_two = wr_go & addr_hit(wa, OFF_CTRL_TWO);
  wire wr_ctrl_three = wr_go & addr_hit(wa, OFF_CTRL_THREE);
  wire wr_ctrl_four = wr_go & addr_hit(wa, OFF_CTRL_FOUR);
  wire wr_int_cfg = wr_go & addr_hit(wa, OFF_INT_CFG);
  wire wr_queue_ctrl = wr_go & addr_hit(wa, OFF_QUEUE_CTRL);
  wire wr_ths_low = wr_go & addr_hit(wa, OFF_THS_LOW);
  wire wr_ths_high = wr_go & addr_hit(wa, OFF_THS_HIGH);
  wire wr_def_low = wr_go & addr_hit(wa, OFF_DEF_P_LOW);
  wire wr_def_high = wr_go & addr_hit(wa, OFF_DEF_P_HIGH);

  // Self-clearing commands and derived control
  wire autozero_clear = ctrl_one_reg[CTRL1_AZ_CLEAR_BIT];
  wire boot_req = ctrl_two_reg[CTRL2_BOOT_BIT];
  wire autozero_req = ctrl_two_reg[CTRL2_AUTOZERO_BIT];
  wire diff_en = ctrl_one_reg[CTRL1_DIFF_EN_BIT];
  wire az_capture = az_reg == AZ_LOAD;
  wire [PRESS_W-1:0] ref_full = {ref_high_reg, ref_mid_reg, ref_low_reg};

  // Reference and threshold arithmetic
  bar_ref_calc u_calc
  (
    .sensor_i(sample_i.pressure),
    .reference_i(ref_full),
    .threshold_i({ths_high_reg, ths_low_reg}),
    .enable_i(diff_en),
    .sum_o(sum_w),
    .high_o(pressure_high_o),
    .low_o(pressure_low_o)
  );

  // Averaging count decode
  bar_avg_decode u_avg
  (
    .avg_cfg_i(avg_cfg_reg),
    .pressure_avg_count_o(pressure_avg_count_o),
    .temp_avg_count_o(temp_avg_count_o)
  );

  // Autozero sequencer: wait for a fresh sample, then take it as reference
  always_comb
  begin
    az_next = az_reg;
    unique case (az_reg)
      AZ_IDLE: if (autozero_req) az_next = AZ_WAIT;
      AZ_WAIT: if (sample_i.valid) az_next = AZ_LOAD;
      AZ_LOAD: az_next = AZ_IDLE;
      default: az_next = AZ_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      az_reg <= AZ_IDLE;
    else if (ce_i)
      az_reg <= az_next;
  end

  // Next values of the reference bytes: clear wins, then capture, then host write
  wire [DATA_W-1:0] ref_low_next = autozero_clear ? RST_ZERO :
    az_capture ? sample_i.pressure[7:0] : req_i.wdata;
  wire [DATA_W-1:0] ref_mid_next = autozero_clear ? RST_ZERO :
    az_capture ? sample_i.pressure[15:8] : req_i.wdata;
  wire [DATA_W-1:0] ref_high_next = autozero_clear ? RST_ZERO :
    az_capture ? sample_i.pressure[23:16] : req_i.wdata;
  wire ref_load = autozero_clear | az_capture;

  // Reference pressure bytes
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ref_low_reg <= RST_ZERO;
      ref_mid_reg <= RST_ZERO;
      ref_high_reg <= RST_ZERO;
    end
    else if (ce_i)
    begin
      if (ref_load | wr_ref_low) ref_low_reg <= ref_low_next;
      if (ref_load | wr_ref_mid) ref_mid_reg <= ref_mid_next;
      if (ref_load | wr_ref_high) ref_high_reg <= ref_high_next;
    end
  end

  // Averaging configuration, reserved upper bits held at zero
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      avg_cfg_reg <= RST_AVG_CFG;
    else if (ce_i && wr_avg_cfg)
      avg_cfg_reg <= req_i.wdata & AVG_CFG_MASK;
  end

  // Control bytes; the autozero clear, boot and autozero bits clear themselves
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      ctrl_one_reg <= RST_ZERO;
      ctrl_two_reg <= RST_ZERO;
      ctrl_three_reg <= RST_ZERO;
      ctrl_four_reg <= RST_ZERO;
      int_cfg_reg <= RST_ZERO;
      queue_ctrl_reg <= RST_ZERO;
      ths_low_reg <= RST_ZERO;
      ths_high_reg <= RST_ZERO;
    end
    else if (ce_i)
    begin
      if (wr_ctrl_one) ctrl_one_reg <= req_i.wdata;
      else if (autozero_clear) ctrl_one_reg[CTRL1_AZ_CLEAR_BIT] <= 1'b0;
      if (wr_ctrl_two) ctrl_two_reg <= req_i.wdata;
      else
      begin
        if (boot_req) ctrl_two_reg[CTRL2_BOOT_BIT] <= 1'b0;
        if (az_capture) ctrl_two_reg[CTRL2_AUTOZERO_BIT] <= 1'b0;
      end
      if (wr_ctrl_three) ctrl_three_reg <= req_i.wdata;
      if (wr_ctrl_four) ctrl_four_reg <= req_i.wdata;
      if (wr_int_cfg) int_cfg_reg <= req_i.wdata;
      if (wr_queue_ctrl) queue_ctrl_reg <= req_i.wdata;
      if (wr_ths_low) ths_low_reg <= req_i.wdata;
      if (wr_ths_high) ths_high_reg <= req_i.wdata;
    end
  end

  // Calibration defaults, restored at reset and by a reboot request
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      def_low_reg <= RST_DEF_P_LOW;
      def_high_reg <= RST_DEF_P_HIGH;
    end
    else if (ce_i)
    begin
      if (boot_req)
      begin
        def_low_reg <= RST_DEF_P_LOW;
        def_high_reg <= RST_DEF_P_HIGH;
      end
      else
      begin
        if (wr_def_low) def_low_reg <= req_i.wdata;
        if (wr_def_high) def_high_reg <= req_i.wdata;
      end
    end
  end

  // Result registers follow the measurement chain only; host writes never reach them
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      press_reg <= {PRESS_W{1'b0}};
      temp_reg <= {TEMP_W{1'b0}};
    end
    else if (ce_i && sample_i.valid)
    begin
      press_reg <= sum_w;
      temp_reg <= sample_i.temperature;
    end
  end

  // Read multiplexer; read-only and reserved addresses decode here only
  function automatic logic [DATA_W-1:0] rd_pick(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFF_REF_LOW: return ref_low_reg;
      OFF_REF_MID: return ref_mid_reg;
      OFF_REF_HIGH: return ref_high_reg;
      OFF_IDENT: return IDENT_CODE;
      OFF_AVG_CFG: return avg_cfg_reg;
      OFF_CTRL_ONE: return ctrl_one_reg;
      OFF_CTRL_TWO: return ctrl_two_reg;
      OFF_CTRL_THREE: return ctrl_three_reg;
      OFF_CTRL_FOUR: return ctrl_four_reg;
      OFF_INT_CFG: return int_cfg_reg;
      OFF_INT_CAUSE: return int_cause_i;
      OFF_SAMPLE_STATE: return sample_state_i;
      OFF_PRESS_LOW: return press_reg[7:0];
      OFF_PRESS_MID: return press_reg[15:8];
      OFF_PRESS_HIGH: return press_reg[23:16];
      OFF_TEMP_LOW: return temp_reg[7:0];
      OFF_TEMP_HIGH: return temp_reg[15:8];
      OFF_QUEUE_CTRL: return queue_ctrl_reg;
      OFF_QUEUE_STATE: return queue_state_i;
      OFF_THS_LOW: return ths_low_reg;
      OFF_THS_HIGH: return ths_high_reg;
      OFF_DEF_P_LOW: return def_low_reg;
      OFF_DEF_P_HIGH: return def_high_reg;
      default: return RST_ZERO;
    endcase
  endfunction : rd_pick

  wire [DATA_W-1:0] rd_value = rd_pick(req_i.addr);

  // Registered read answer, one cycle after the request
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rdata_reg <= RST_ZERO;
      rvalid_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      rvalid_reg <= req_i.rd;
      if (req_i.rd) rdata_reg <= rd_value;
    end
  end

  // Outputs
  assign rdata_o = rdata_reg;
  assign rvalid_o = rvalid_reg;
  assign reference_o = ref_full;
  assign ctrl_o = '{ctrl_one: ctrl_one_reg, ctrl_two: ctrl_two_reg,
    ctrl_three: ctrl_three_reg, ctrl_four: ctrl_four_reg, int_cfg: int_cfg_reg,
    queue_ctrl: queue_ctrl_reg, threshold: {ths_high_reg, ths_low_reg},
    default_pressure: {def_high_reg, def_low_reg}};

  // Checks
  sequence s_clear_cmd;
    ce_i && autozero_clear;
  endsequence

  a_ref_write_lands: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_ref_mid && !ref_load |=> ref_mid_reg == $past(req_i.wdata))
    else $error("reference middle byte write lost");
  a_sum_reported: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && sample_i.valid |=> press_reg == $past(sample_i.pressure) + $past(ref_full))
    else $error("reported pressure is not sensor plus reference");
  a_az_clear_ref: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    s_clear_cmd |=> ref_full == {PRESS_W{1'b0}} && !autozero_clear)
    else $error("autozero clear did not zero the reference");
  a_ident_fixed: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && req_i.rd && req_i.addr == OFF_IDENT |=> rvalid_o && rdata_o == IDENT_CODE)
    else $error("identification read wrong");
  a_pavg_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    avg_cfg_reg[AVG_P_LSB +: 2] == 2'h3 |-> pressure_avg_count_o == PAVG_512)
    else $error("pressure average decode wrong");
  a_tavg_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    avg_cfg_reg[AVG_T_LSB +: 2] == 2'h1 |-> temp_avg_count_o == TAVG_16)
    else $error("temperature average decode wrong");
  a_avg_upper_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_avg_cfg |=> avg_cfg_reg[7:4] == 4'h0 && avg_cfg_reg[3:0] == $past(req_i.wdata[3:0]))
    else $error("averaging register upper bits not zero");
  a_boot_restore: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && boot_req |=> def_low_reg == RST_DEF_P_LOW && def_high_reg == RST_DEF_P_HIGH)
    else $error("calibration defaults not restored");
  a_ro_untouched: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && req_i.wr && !sample_i.valid |=> $stable(press_reg) && $stable(temp_reg))
    else $error("host write changed a result register");
  a_reserved_zero: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ce_i && req_i.rd && req_i.addr inside {[7'h00:7'h07], 7'h0D, 7'h0E, [7'h11:7'h1F]}
    |=> rdata_o == RST_ZERO)
    else $error("reserved address did not read zero");

endmodule : bar_register_map

// ===== verification/bar_host_model.sv
// Host model that issues single-byte register requests to the bank
`timescale 1ns/1ps
module bar_host_model
(
  input wire logic clk_i,
  output bar_pkg::bar_req_t req_o,
  input wire logic [bar_pkg::DATA_W-1:0] rdata_i,
  input wire logic rvalid_i
);
  import bar_pkg::*;

  initial req_o = '0;

  // Reserved ranges that a write could damage
  function automatic logic is_reserved(input logic [ADDR_W-1:0] a);
    return a <= 7'h07 || a == 7'h0D || a == 7'h0E || (a >= 7'h11 && a <= 7'h1F)
      || a == 7'h26 || a == 7'h2D || (a >= 7'h32 && a <= 7'h38);
  endfunction : is_reserved

  // One write, held for one clock edge whether or not the clock enable is high; idle lines show inverted data
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    if (is_reserved(a))
    begin
      $display("host skips write to reserved address %h", a);
      return;
    end
    @(posedge clk_i);
    req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : wr

  // One read; data taken at the edge where the valid pulse is seen
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req_o <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (rvalid_i !== 1'b1 && n < 8);
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask : rd
endmodule : bar_host_model

// ===== verification/bar_register_map_tb.sv
// Self-checking testbench of the barometer register bank
`timescale 1ns/1ps
module bar_register_map_tb;
  import bar_pkg::*;

  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic ce = 1'b1;
  bar_req_t req;
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  bar_sample_t sample_i = '0;
  bar_ctrl_t ctrl;
  logic [PRESS_W-1:0] reference;
  logic p_high;
  logic p_low;
  logic [PAVG_W-1:0] pcount;
  logic [TAVG_W-1:0] tcount;
  int bad_count = 0;
  int tests_run = 0;

  // Clock of 100 ns period
  initial forever #50 clk_i = ~clk_i;

  bar_host_model i_host (.clk_i(clk_i), .req_o(req), .rdata_i(rdata), .rvalid_i(rvalid));

  bar_register_map i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .ce_i(ce), .req_i(req),
    .rdata_o(rdata), .rvalid_o(rvalid), .sample_i(sample_i), .int_cause_i(8'hA5),
    .sample_state_i(8'h3C), .queue_state_i(8'hC3), .ctrl_o(ctrl), .reference_o(reference),
    .pressure_high_o(p_high), .pressure_low_o(p_low), .pressure_avg_count_o(pcount),
    .temp_avg_count_o(tcount));

  // Compare and report
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Read a register and compare it
  task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_host.rd(a, d);
    chk($sformatf("reg %h", a), {16'h0000, d}, {16'h0000, exp});
  endtask : rchk

  // One measurement pulse; the raw value stays on the lines afterwards
  task automatic pulse(input logic [23:0] p, input logic [15:0] t);
    @(posedge clk_i);
    sample_i <= '{valid: 1'b1, pressure: p, temperature: t};
    @(posedge clk_i);
    sample_i.valid <= 1'b0;
    #1;
  endtask : pulse

  task automatic t_reset();
    logic [6:0] ra [15] = '{7'h08, 7'h09, 7'h0A, 7'h10, 7'h20, 7'h21, 7'h22, 7'h23, 7'h24,
      7'h2E, 7'h30, 7'h31, 7'h39, 7'h3A, 7'h25};
    logic [7:0] ex;
    chk("pressure count", {14'h0, pcount}, {14'h0, PAVG_32});
    chk("temperature count", {17'h0, tcount}, {17'h0, TAVG_16});
    // Address 25h returns the interrupt cause input, tied to A5h here
    foreach (ra[i])
    begin
      ex = ra[i] == 7'h10 ? 8'h05 : ra[i] == 7'h39 ? 8'h38 : 8'h00;
      rchk(ra[i], ra[i] == 7'h25 ? 8'hA5 : ex);
    end
    rchk(7'h0F, IDENT_CODE);
    $display("test reset done");
  endtask : t_reset

  task automatic t_readonly();
    logic [6:0] ra [9] = '{7'h0F, 7'h25, 7'h27, 7'h28, 7'h29, 7'h2A, 7'h2B, 7'h2C, 7'h2F};
    logic [7:0] ex [9] = '{IDENT_CODE, 8'hA5, 8'h3C, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hC3};
    foreach (ra[i])
      i_host.wr(ra[i], 8'hFF);
    foreach (ra[i])
      rchk(ra[i], ex[i]);
    $display("test read-only done");
  endtask : t_readonly

  task automatic t_ref();
    i_host.wr(7'h08, 8'h34);
    i_host.wr(7'h09, 8'h12);
    i_host.wr(7'h0A, 8'hF0);
    // Let the last write land before looking
    #1;
    chk("reference", reference, 24'hF01234);
    rchk(7'h08, 8'h34);
    rchk(7'h0A, 8'hF0);
    $display("test reference done");
  endtask : t_ref

  task automatic t_reserved();
    logic [6:0] ra [10] = '{7'h00, 7'h07, 7'h0D, 7'h0E, 7'h11, 7'h1F, 7'h26, 7'h2D, 7'h32, 7'h38};
    foreach (ra[i])
      rchk(ra[i], 8'h00);
    chk("reference after reads", reference, 24'hF01234);
    $display("test reserved done");
  endtask : t_reserved

  task automatic t_sum();
    pulse(24'h0FFF00, 16'hBEEF);
    rchk(7'h28, 8'h34);
    rchk(7'h29, 8'h11);
    rchk(7'h2A, 8'h00);
    rchk(7'h2B, 8'hEF);
    rchk(7'h2C, 8'hBE);
    $display("test sum done");
  endtask : t_sum

  task automatic t_avg();
    int pe [4] = '{8, 32, 128, 512};
    int te [4] = '{8, 16, 32, 64};
    for (int p = 0; p < 4; p++)
      for (int t = 0; t < 4; t++)
      begin
        i_host.wr(7'h10, {4'hF, 2'(p), 2'(t)});
        #1;
        chk("pressure count", {14'h0, pcount}, 24'(pe[p]));
        chk("temperature count", {17'h0, tcount}, 24'(te[t]));
        rchk(7'h10, {4'h0, 2'(p), 2'(t)});
      end
    $display("test averaging done");
  endtask : t_avg

  task automatic t_thresh();
    int off [3] = '{17, -17, 16};
    logic eh [3] = '{1'b1, 1'b0, 1'b0};
    logic el [3] = '{1'b0, 1'b1, 1'b0};
    i_host.wr(7'h30, 8'h10);
    i_host.wr(7'h31, 8'h00);
    i_host.wr(7'h20, 8'h08);
    #1;
    chk("threshold", {8'h00, ctrl.threshold}, 24'h000010);
    foreach (off[i])
    begin
      pulse(24'hF01234 + 24'(off[i]), 16'h0000);
      chk("pressure high", {23'h0, p_high}, {23'h0, eh[i]});
      chk("pressure low", {23'h0, p_low}, {23'h0, el[i]});
    end
    $display("test threshold done");
  endtask : t_thresh

  task automatic t_autozero();
    i_host.wr(7'h20, 8'h0A);
    repeat (3) @(posedge clk_i);
    chk("reference cleared", reference, 24'h000000);
    rchk(7'h20, 8'h08);
    i_host.wr(7'h21, 8'h02);
    pulse(24'h123456, 16'h0001);
    repeat (2) @(posedge clk_i);
    chk("reference captured", reference, 24'h123456);
    rchk(7'h21, 8'h00);
    $display("test autozero done");
  endtask : t_autozero

  // A write offered while the clock enable is low must not land
  task automatic t_hold();
    @(posedge clk_i);
    ce <= 1'b0;
    i_host.wr(7'h08, 8'hEE);
    @(posedge clk_i);
    ce <= 1'b1;
    #1;
    chk("reference frozen", reference, 24'h123456);
    rchk(7'h08, 8'h56);
    $display("test clock enable done");
  endtask : t_hold

  task automatic t_boot();
    i_host.wr(7'h39, 8'h77);
    i_host.wr(7'h3A, 8'h66);
    rchk(7'h39, 8'h77);
    i_host.wr(7'h21, 8'h80);
    repeat (3) @(posedge clk_i);
    chk("calibration", {8'h00, ctrl.default_pressure}, 24'h000038);
    rchk(7'h3A, 8'h00);
    rchk(7'h21, 8'h00);
    $display("test boot done");
  endtask : t_boot

  // Verdict and end of run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_reset();
    t_readonly();
    t_ref();
    t_reserved();
    t_sum();
    t_avg();
    t_thresh();
    t_autozero();
    t_hold();
    t_boot();
    test_done();
  end

  // Watchdog well beyond the expected run of under a thousand cycles
  initial
  begin
    #(5000 * 100);
    bad_count++;
    test_done();
  end
endmodule : bar_register_map_tb
